// *** async_serial_tx_rx_core.sv ***
`timescale 1ns/1ps
module async_serial_tx_rx_core
	import uart_core_pkg::*;
#(
	parameter logic [15:0] BAUD_DIV_RESET = uart_core_pkg::BAUD_RESET
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic irq
);
	import uart_core_pkg::*;

	if (BAUD_DIV_RESET == 16'h0000)
	begin : g_chk
		$error("baud divider reset value must be nonzero");
	end

	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic b_vld;
		logic [1:0] b_resp;
		logic ar_rdy;
		logic r_vld;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [9:0] ctrl;
		logic [15:0] baud;
		logic [15:0] baud_cnt;
		logic seen;
		logic txe;
		logic txd;
		logic rxf;
		logic idle;
		logic ovr;
		logic noise;
		logic frm;
		logic irq;
		tx_state_e tx_state;
		logic [10:0] tx_shift;
		logic [3:0] tx_left;
		logic [3:0] tx_sub;
		logic [8:0] tx_hold;
		logic hold_full;
		logic pre_pend;
		logic txon_prev;
		logic tx_line;
		logic s1;
		logic s2;
		rx_state_e rx_state;
		logic [3:0] rx_sub;
		logic [3:0] rx_idx;
		logic [1:0] votes;
		logic rx_nz;
		logic [8:0] rx_shift;
		logic [7:0] rx_hold;
		logic r8;
		logic idle_arm;
		logic [7:0] idle_cnt;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic tick;
	logic wr_fire;
	logic rd_fire;
	logic tx_job_end;
	logic rx_done;
	logic rx_bad;

	assign tick = (st_r.baud_cnt == 16'h0000);
	assign wr_fire = st_r.aw_rdy;
	assign rd_fire = st_r.ar_rdy;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic wl;
		logic pick;
		logic [2:0] tot;
		logic maj;
		wl = st_r.ctrl[CTL_WL];
		pick = 1'b0;
		tot = 3'h0;
		maj = 1'b0;
		tx_job_end = 1'b0;
		rx_done = 1'b0;
		rx_bad = 1'b0;
		st_nxt = st_r;
		st_nxt.baud_cnt = tick ? st_r.baud : st_r.baud_cnt - 16'h0001;

		// axi4-lite write channel: ready pulses one cycle, master holds valid
		if (st_r.b_vld && s_axi_bready)
			st_nxt.b_vld = 1'b0;
		if (!st_r.b_vld && !st_r.aw_rdy && s_axi_awvalid && s_axi_wvalid)
		begin
			st_nxt.aw_rdy = 1'b1;
			st_nxt.w_rdy = 1'b1;
		end
		if (wr_fire)
		begin
			st_nxt.aw_rdy = 1'b0;
			st_nxt.w_rdy = 1'b0;
			st_nxt.b_vld = 1'b1;
			st_nxt.b_resp = RESP_OKAY;
			case (s_axi_awaddr)
				ADDR_DATA:
				begin
					if (s_axi_wstrb[0])
					begin
						st_nxt.tx_hold = {st_r.ctrl[CTL_T8], s_axi_wdata[7:0]};
						st_nxt.hold_full = 1'b1;
						if (st_r.seen)
						begin
							st_nxt.txe = 1'b0;
							st_nxt.txd = 1'b0;
						end
						st_nxt.seen = 1'b0;
					end
				end
				ADDR_CTRL:
				begin
					if (s_axi_wstrb[0])
						st_nxt.ctrl[7:0] = s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						st_nxt.ctrl[9:8] = s_axi_wdata[9:8];
				end
				ADDR_BAUD:
				begin
					if (s_axi_wstrb[0])
						st_nxt.baud[7:0] = s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						st_nxt.baud[15:8] = s_axi_wdata[15:8];
				end
				ADDR_STATUS:
					st_nxt.b_resp = RESP_OKAY;
				default:
					st_nxt.b_resp = RESP_DECERR;
			endcase
		end

		// axi4-lite read channel
		if (st_r.r_vld && s_axi_rready)
			st_nxt.r_vld = 1'b0;
		if (!st_r.r_vld && !st_r.ar_rdy && s_axi_arvalid)
			st_nxt.ar_rdy = 1'b1;
		if (rd_fire)
		begin
			st_nxt.ar_rdy = 1'b0;
			st_nxt.r_vld = 1'b1;
			st_nxt.r_resp = RESP_OKAY;
			st_nxt.r_data = 32'h0000_0000;
			case (s_axi_araddr)
				ADDR_DATA:
				begin
					st_nxt.r_data[7:0] = st_r.rx_hold;
					if (st_r.seen)
					begin
						st_nxt.rxf = 1'b0;
						st_nxt.ovr = 1'b0;
						st_nxt.noise = 1'b0;
						st_nxt.frm = 1'b0;
						st_nxt.idle = 1'b0;
					end
					st_nxt.seen = 1'b0;
				end
				ADDR_STATUS:
				begin
					st_nxt.r_data[ST_TXE] = st_r.txe;
					st_nxt.r_data[ST_TXD] = st_r.txd;
					st_nxt.r_data[ST_RXF] = st_r.rxf;
					st_nxt.r_data[ST_IDLE] = st_r.idle;
					st_nxt.r_data[ST_OVR] = st_r.ovr;
					st_nxt.r_data[ST_NOISE] = st_r.noise;
					st_nxt.r_data[ST_FRM] = st_r.frm;
					st_nxt.seen = 1'b1;
				end
				ADDR_CTRL:
				begin
					st_nxt.r_data[9:0] = st_r.ctrl;
					st_nxt.r_data[CTL_R8] = st_r.r8;
				end
				ADDR_BAUD:
					st_nxt.r_data[15:0] = st_r.baud;
				default:
					st_nxt.r_resp = RESP_DECERR;
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// transmitter
		st_nxt.txon_prev = st_r.ctrl[CTL_TXON];
		if (st_r.ctrl[CTL_TXON] != st_r.txon_prev)
		begin
			st_nxt.hold_full = 1'b0;
			st_nxt.txe = 1'b1;
			st_nxt.pre_pend = st_r.ctrl[CTL_TXON];
		end
		if (st_r.tx_state == TX_IDLE)
			pick = 1'b1;
		else if (tick)
		begin
			if (st_r.tx_sub == SUB_LAST)
			begin
				st_nxt.tx_sub = 4'h0;
				st_nxt.tx_shift = {1'b1, st_r.tx_shift[10:1]};
				st_nxt.tx_left = st_r.tx_left - 4'h1;
				if (st_r.tx_left == 4'h1)
				begin
					tx_job_end = 1'b1;
					if (st_r.tx_state == TX_DATA || st_r.tx_state == TX_BREAK)
						st_nxt.txd = 1'b1;
					if (st_r.tx_state == TX_BREAK && st_r.ctrl[CTL_SBK])
					begin
						st_nxt.tx_shift = 11'h000;
						st_nxt.tx_left = wl ? FRAME_BITS9 : FRAME_BITS8;
					end
					else if (st_r.tx_state == TX_BREAK)
					begin
						st_nxt.tx_state = TX_MARK;
						st_nxt.tx_shift = 11'h7ff;
						st_nxt.tx_left = 4'h1;
					end
					else
						pick = 1'b1;
				end
			end
			else
				st_nxt.tx_sub = st_r.tx_sub + 4'h1;
		end
		if (pick)
		begin
			st_nxt.tx_state = TX_IDLE;
			st_nxt.tx_sub = 4'h0;
			st_nxt.tx_shift = 11'h7ff;
			if (!st_r.ctrl[CTL_TXON])
				st_nxt.tx_left = 4'h0;
			else if (st_nxt.pre_pend)
			begin
				st_nxt.pre_pend = 1'b0;
				st_nxt.tx_state = TX_PRE;
				st_nxt.tx_left = wl ? FRAME_BITS9 : FRAME_BITS8;
			end
			else if (st_r.ctrl[CTL_SBK])
			begin
				st_nxt.tx_state = TX_BREAK;
				st_nxt.tx_shift = 11'h000;
				st_nxt.tx_left = wl ? FRAME_BITS9 : FRAME_BITS8;
			end
			else if (st_nxt.hold_full)
			begin
				st_nxt.tx_state = TX_DATA;
				st_nxt.hold_full = 1'b0;
				st_nxt.txe = 1'b1;
				st_nxt.tx_shift = wl ? {1'b1, st_nxt.tx_hold, 1'b0}
					: {2'b11, st_nxt.tx_hold[7:0], 1'b0};
				st_nxt.tx_left = wl ? FRAME_BITS9 : FRAME_BITS8;
			end
		end
		st_nxt.tx_line = (st_nxt.tx_state == TX_IDLE) ? 1'b1 : st_nxt.tx_shift[0];

		////////////////////////////////////////////////////////////////////////
		// receiver
		st_nxt.s1 = serial_in_pin;
		st_nxt.s2 = st_r.s1;
		if (!st_r.ctrl[CTL_RXEN])
			st_nxt.rx_state = RX_HUNT;
		else if (tick)
		begin
			case (st_r.rx_state)
				RX_HUNT:
				begin
					if (!st_r.s2)
					begin
						st_nxt.rx_state = RX_BITS;
						st_nxt.rx_sub = 4'h1;
						st_nxt.rx_idx = 4'h0;
						st_nxt.votes = 2'h0;
						st_nxt.rx_nz = 1'b0;
						st_nxt.idle_cnt = 8'h00;
					end
					else if (st_r.idle_arm)
					begin
						st_nxt.idle_cnt = st_r.idle_cnt + 8'h01;
						if (st_nxt.idle_cnt == (wl ? IDLE_TICKS9 : IDLE_TICKS8))
						begin
							st_nxt.idle = 1'b1;
							st_nxt.idle_arm = 1'b0;
						end
					end
				end
				RX_BITS:
				begin
					if (st_r.rx_sub == SAMPLE_A || st_r.rx_sub == SAMPLE_B)
						st_nxt.votes = st_r.votes + {1'b0, st_r.s2};
					if (st_r.rx_sub == SAMPLE_C)
					begin
						tot = {1'b0, st_r.votes} + {2'b00, st_r.s2};
						maj = (tot >= 3'h2);
						st_nxt.rx_nz = st_r.rx_nz | (tot != 3'h0 && tot != 3'h3);
						if (st_r.rx_idx == 4'h0)
						begin
							if (maj)
								st_nxt.rx_state = RX_HUNT;
						end
						else if (st_r.rx_idx == (wl ? STOP_IDX9 : STOP_IDX8))
						begin
							rx_done = 1'b1;
							rx_bad = !maj;
							st_nxt.rx_state = RX_HUNT;
						end
						else
							st_nxt.rx_shift = {maj, st_r.rx_shift[8:1]};
					end
					if (st_r.rx_sub == SUB_LAST)
					begin
						st_nxt.rx_sub = 4'h0;
						st_nxt.rx_idx = st_r.rx_idx + 4'h1;
						st_nxt.votes = 2'h0;
					end
					else
						st_nxt.rx_sub = st_r.rx_sub + 4'h1;
				end
				default:
					st_nxt.rx_state = RX_HUNT;
			endcase
		end
		if (rx_done)
		begin
			st_nxt.idle_arm = 1'b1;
			st_nxt.idle_cnt = 8'h00;
			if (st_nxt.rxf)
				st_nxt.ovr = 1'b1;
			else
			begin
				st_nxt.rx_hold = wl ? st_r.rx_shift[7:0] : st_r.rx_shift[8:1];
				st_nxt.r8 = wl & st_r.rx_shift[8];
				st_nxt.rxf = 1'b1;
				st_nxt.noise = st_nxt.noise | st_nxt.rx_nz;
				st_nxt.frm = st_nxt.frm | rx_bad;
			end
		end

		st_nxt.irq = (st_nxt.txe & st_nxt.ctrl[CTL_TIE])
			| (st_nxt.txd & st_nxt.ctrl[CTL_TX_DONE_IRQ_ON])
			| ((st_nxt.rxf | st_nxt.ovr) & st_nxt.ctrl[CTL_RIE])
			| (st_nxt.idle & st_nxt.ctrl[CTL_IDLE_IRQ_ON]);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RESET;
			st_r.baud <= BAUD_DIV_RESET;
			st_r.txe <= TXE_RESET;
			st_r.txd <= TXD_RESET;
			st_r.tx_state <= TX_IDLE;
			st_r.rx_state <= RX_HUNT;
			st_r.tx_shift <= 11'h7ff;
			st_r.tx_line <= 1'b1;
			st_r.s1 <= 1'b1;
			st_r.s2 <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign s_axi_awready = st_r.aw_rdy;
	assign s_axi_wready = st_r.w_rdy;
	assign s_axi_bvalid = st_r.b_vld;
	assign s_axi_bresp = st_r.b_resp;
	assign s_axi_arready = st_r.ar_rdy;
	assign s_axi_rvalid = st_r.r_vld;
	assign s_axi_rdata = st_r.r_data;
	assign s_axi_rresp = st_r.r_resp;
	assign serial_out_pin = st_r.tx_line;
	assign irq = st_r.irq;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	preamble_start_a: assert property ($rose(st_r.ctrl[CTL_TXON]) && st_r.tx_state == TX_IDLE
		|=> ##1 st_r.tx_state == TX_PRE && serial_out_pin)
		else $error("preamble not started after tx_on");
	preamble_len_a: assert property ($rose(st_r.tx_state == TX_PRE) |-> st_r.tx_left ==
		(st_r.ctrl[CTL_WL] ? FRAME_BITS9 : FRAME_BITS8))
		else $error("preamble length wrong");
	direct_load_a: assert property (wr_fire && s_axi_awaddr == ADDR_DATA && s_axi_wstrb[0]
		&& st_r.tx_state == TX_IDLE && st_r.ctrl[CTL_TXON] && st_r.txon_prev && !st_r.ctrl[CTL_SBK]
		|=> st_r.tx_state == TX_DATA && st_r.txe && !serial_out_pin)
		else $error("idle write did not start transmission");
	busy_hold_a: assert property (wr_fire && s_axi_awaddr == ADDR_DATA && s_axi_wstrb[0]
		&& st_r.tx_state == TX_DATA && !tx_job_end && st_r.ctrl[CTL_TXON] == st_r.txon_prev
		|=> st_r.hold_full && st_r.tx_state == TX_DATA)
		else $error("busy write not held");
	empty_clear_a: assert property (wr_fire && s_axi_awaddr == ADDR_DATA && s_axi_wstrb[0]
		&& st_r.seen && st_r.tx_state == TX_DATA && !tx_job_end
		&& st_r.ctrl[CTL_TXON] == st_r.txon_prev |=> !st_r.txe && !st_r.txd)
		else $error("clear sequence failed on tx flags");
	break_low_a: assert property (st_r.tx_state == TX_BREAK |-> !serial_out_pin)
		else $error("line high during break");
	rx_clear_a: assert property (rd_fire && s_axi_araddr == ADDR_DATA && st_r.seen && !rx_done
		|=> !st_r.rxf && !st_r.ovr && !st_r.frm && !st_r.noise)
		else $error("clear sequence failed on rx flags");
	overrun_keep_a: assert property (rx_done && st_r.rxf && !(rd_fire && st_r.seen)
		|=> st_r.ovr && $stable(st_r.rx_hold))
		else $error("overrun mishandled");
	frame_err_a: assert property (rx_done && rx_bad && !st_r.rxf |=> st_r.frm && st_r.rxf)
		else $error("framing error not flagged");
	irq_follow_a: assert property (st_r.rxf && st_r.ctrl[CTL_RIE] |-> irq)
		else $error("receive interrupt missing");

	direct_send_c: cover property (st_r.tx_state == TX_IDLE ##1 st_r.tx_state == TX_DATA);
	break_mark_c: cover property (st_r.tx_state == TX_BREAK ##1 st_r.tx_state == TX_MARK);
	overrun_c: cover property (rx_done && st_r.rxf);
	idle_line_c: cover property ($rose(st_r.idle));
endmodule

// *** uart_core_pkg.sv ***
package uart_core_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_DATA = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0008;
	localparam logic [31:0] ADDR_BAUD = 32'h0000_000c;
	// control_one_reg fields
	localparam int CTL_WL = 0;
	localparam int CTL_T8 = 1;
	localparam int CTL_R8 = 2;
	localparam int CTL_TXON = 3;
	localparam int CTL_RXEN = 4;
	localparam int CTL_SBK = 5;
	localparam int CTL_TIE = 6;
	localparam int CTL_TX_DONE_IRQ_ON = 7;
	localparam int CTL_RIE = 8;
	localparam int CTL_IDLE_IRQ_ON = 9;
	localparam int CTL_W = 10;
	localparam logic [9:0] CTRL_RESET = 10'h000;
	// status_flags_reg fields
	localparam int ST_FRM = 1;
	localparam int ST_NOISE = 2;
	localparam int ST_OVR = 3;
	localparam int ST_IDLE = 4;
	localparam int ST_RXF = 5;
	localparam int ST_TXD = 6;
	localparam int ST_TXE = 7;
	localparam logic TXE_RESET = 1'b1;
	localparam logic TXD_RESET = 1'b1;
	// baud_divider_reg: aclk cycles per oversample tick, minus one
	localparam logic [15:0] BAUD_RESET = 16'h0043;
	// serial timing in oversample ticks
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] FRAME_BITS8 = 4'ha;
	localparam logic [3:0] FRAME_BITS9 = 4'hb;
	localparam logic [3:0] STOP_IDX8 = 4'h9;
	localparam logic [3:0] STOP_IDX9 = 4'ha;
	localparam logic [7:0] IDLE_TICKS8 = 8'(10 * OVERSAMPLE);
	localparam logic [7:0] IDLE_TICKS9 = 8'(11 * OVERSAMPLE);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BREAK, TX_MARK} tx_state_e;
	typedef enum logic [0:0] {RX_HUNT, RX_BITS} rx_state_e;
endpackage

// *** serial_link_node.sv ***
`timescale 1ns/1ps
module serial_link_node #(
	parameter int BIT_CLKS = 32
)(
	input wire logic aclk,
	input wire logic line_in,
	output logic line_out
);
	logic [9:0] got_q[$];
	logic nine = 1'h0;
	initial line_out = 1'h1;
	////////////////////////////////////////////////////////////////
	// start, data lsb first, stop; gb picks a bit that gets a one-tick centre glitch
	task automatic send(input logic [8:0] d, input logic stop, input int gb);
		logic [10:0] f;
		int n;
		n = nine ? 11 : 10;
		f = nine ? {stop, d, 1'h0} : {1'h0, stop, d[7:0], 1'h0};
		for (int i = 0; i < n; i++)
			for (int c = 0; c < BIT_CLKS; c++)
			begin
				line_out <= f[i] ^ (i == gb && c >= 16 && c < 18);
				@(posedge aclk);
			end
		line_out <= 1'h1;
		@(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////
	// samples mid-bit; v[9] is the stop position, so a break reads as all zeros
	initial forever
	begin
		logic [9:0] v;
		@(negedge line_in);
		v = 10'h0;
		repeat (BIT_CLKS / 2) @(posedge aclk);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			repeat (BIT_CLKS) @(posedge aclk);
			v[i] = line_in;
		end
		repeat (BIT_CLKS) @(posedge aclk);
		v[9] = line_in;
		got_q.push_back(v);
		if (!line_in)
			@(posedge line_in);
	end
endmodule

// *** async_serial_tx_rx_core_test.sv ***
`timescale 1ns/1ps
module async_serial_tx_rx_core_test;
	import uart_core_pkg::*;
	localparam logic [31:0] on_tx = 32'h1 << CTL_TXON;
	localparam logic [31:0] on_rx = 32'h1 << CTL_RXEN;
	localparam logic [31:0] wide9 = 32'h1 << CTL_WL;
	localparam logic [31:0] ninth = 32'h1 << CTL_T8;
	localparam logic [31:0] brk = 32'h1 << CTL_SBK;
	localparam logic [31:0] txe_ie = 32'h1 << CTL_TIE;
	localparam logic [31:0] idle_ie = 32'h1 << CTL_IDLE_IRQ_ON;
	localparam logic [31:0] done_ie = 32'h1 << CTL_TX_DONE_IRQ_ON;
	localparam logic [31:0] rx_ie = 32'h1 << CTL_RIE;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	// response readies stay high: every answer is taken at the edge it is first seen
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic serial_in_pin, serial_out_pin, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0, comparisons = 0;
	always #4 aclk = ~aclk;
	async_serial_tx_rx_core #(.BAUD_DIV_RESET(16'h0001)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin), .irq(irq));
	serial_link_node node (.aclk(aclk), .line_in(serial_out_pin), .line_out(serial_in_pin));
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tmo();
		failures++;
		$display("BAD %0t wait ran out", $time);
		test_done();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1 && n < 50);
		if (n >= 50)
			tmo();
		chk(s_axi_bresp, er, "bresp");
	endtask
	task automatic rx_holding_buffer(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1 && n < 50);
		if (n >= 50)
			tmo();
		d = s_axi_rdata;
		chk(s_axi_rresp, er, "rresp");
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		logic [31:0] v;
		rx_holding_buffer(a, v);
		chk(v & m, e, s);
	endtask
	task automatic poll(input int b, output logic [31:0] s);
		int n = 0;
		do
		begin
			rx_holding_buffer(ADDR_STATUS, s);
			n++;
		end
		while (s[b] !== 1'h1 && n < 600);
		if (n >= 600)
			tmo();
	endtask
	task automatic wait_q(input int k);
		for (int n = 0; node.got_q.size() < k; n++)
		begin
			if (n > 3000)
				tmo();
			@(posedge aclk);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rc(ADDR_STATUS, 32'hffff_ffff, 32'hc0, "status reset");
		rx_holding_buffer(32'h10, rd, RESP_DECERR);
		chk(rd, 32'h0, "unmapped read");
		wr(32'h10, 32'hffff_ffff, RESP_DECERR);
		rc(ADDR_CTRL, 32'hffff_ffff, 32'h0, "ctrl reset");
		rc(ADDR_BAUD, 32'hffff_ffff, 32'h1, "baud reset");
		wr(ADDR_CTRL, txe_ie);
		repeat (3) @(posedge aclk);
		chk(irq, 32'h1, "irq on empty");
		wr(ADDR_CTRL, 32'h0);
		repeat (3) @(posedge aclk);
		chk(irq, 32'h0, "irq masked off");
		$display("done regs");
	endtask
	task automatic t_tx8();
		time t0;
		int n = 0;
		wr(ADDR_CTRL, on_tx);
		t0 = $time;
		wr(ADDR_DATA, 32'ha5);
		while (serial_out_pin !== 1'h0 && n++ < 600)
			@(posedge aclk);
		chk(32'(($time - t0) / 8 inside {[310:335]}), 32'h1, "preamble length");
		rx_holding_buffer(ADDR_STATUS, rd);
		wr(ADDR_DATA, 32'h3c);
		rc(ADDR_STATUS, 32'hc0, 32'h0, "flags cleared");
		wait_q(2);
		chk(node.got_q[0], 32'h2a5, "first byte");
		chk(node.got_q[1], 32'h23c, "held byte");
		repeat (24) @(posedge aclk);
		rc(ADDR_STATUS, 32'hc0, 32'hc0, "empty and done");
		wr(ADDR_DATA, 32'h81);
		chk(serial_out_pin, 32'h0, "idle write starts");
		rc(ADDR_STATUS, 32'hc0, 32'h80, "empty set at once");
		wait_q(3);
		chk(node.got_q[2], 32'h281, "direct byte");
		$display("done tx8");
	endtask
	task automatic t_tx9();
		node.nine = 1'h1;
		wr(ADDR_CTRL, on_tx | wide9 | ninth);
		rx_holding_buffer(ADDR_STATUS, rd);
		wr(ADDR_DATA, 32'h3c);
		wait_q(4);
		chk(node.got_q[3], 32'h33c, "nine bit word");
		node.nine = 1'h0;
		$display("done tx9");
	endtask
	task automatic t_brk();
		int n = 0;
		int k = 0;
		// let the nine-bit frame finish so its done flag cannot land after the clear
		repeat (40) @(posedge aclk);
		rx_holding_buffer(ADDR_STATUS, rd);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_DATA, 32'h77);
		wr(ADDR_CTRL, on_tx);
		rc(ADDR_STATUS, 32'hc0, 32'h80, "toggle empties buffer");
		wr(ADDR_CTRL, on_tx | brk);
		wait_q(5);
		rc(ADDR_STATUS, 32'h40, 32'h0, "no done mid break");
		wr(ADDR_CTRL, on_tx | done_ie);
		while (k < 40 && n++ < 3000)
		begin
			@(posedge aclk);
			k = serial_out_pin ? k + 1 : 0;
		end
		chk(node.got_q[4], 32'h0, "break all low, held byte dropped");
		rc(ADDR_STATUS, 32'h40, 32'h40, "done after break");
		chk(irq, 32'h1, "done irq");
		$display("done break");
	endtask
	task automatic t_rx();
		wr(ADDR_CTRL, on_rx | rx_ie);
		node.send(9'h05a, 1'h1, -1);
		poll(ST_RXF, rd);
		chk(irq, 32'h1, "full irq");
		chk(rd & 32'he, 32'h0, "clean char");
		rc(ADDR_DATA, 32'hff, 32'h5a, "rx byte");
		rc(ADDR_STATUS, 32'h20, 32'h0, "full cleared");
		chk(irq, 32'h0, "full irq gone");
		poll(ST_IDLE, rd);
		wr(ADDR_CTRL, on_rx | idle_ie);
		repeat (3) @(posedge aclk);
		chk(irq, 32'h1, "idle irq");
		rx_holding_buffer(ADDR_DATA, rd);
		node.nine = 1'h1;
		wr(ADDR_CTRL, on_rx | wide9);
		node.send(9'h1a5, 1'h1, -1);
		poll(ST_RXF, rd);
		rc(ADDR_DATA, 32'hff, 32'ha5, "rx low byte");
		rc(ADDR_CTRL, 32'h4, 32'h4, "rx ninth bit");
		node.nine = 1'h0;
		wr(ADDR_CTRL, on_rx);
		$display("done rx");
	endtask
	task automatic t_ovr();
		node.send(9'h011, 1'h1, -1);
		node.send(9'h022, 1'h1, -1);
		poll(ST_OVR, rd);
		chk(rd & 32'h20, 32'h20, "full kept");
		rc(ADDR_DATA, 32'hff, 32'h11, "first kept");
		rc(ADDR_STATUS, 32'h28, 32'h0, "overrun cleared");
		$display("done overrun");
	endtask
	task automatic t_err();
		node.send(9'h066, 1'h1, 3);
		poll(ST_RXF, rd);
		chk(rd & 32'h6, 32'h4, "noise flag");
		rc(ADDR_DATA, 32'hff, 32'h66, "noisy data kept");
		node.send(9'h05b, 1'h0, -1);
		poll(ST_RXF, rd);
		chk(rd & 32'h2, 32'h2, "bad stop");
		rc(ADDR_DATA, 32'hff, 32'h5b, "bad stop data");
		node.send(9'h000, 1'h0, -1);
		poll(ST_RXF, rd);
		chk(rd & 32'h2, 32'h2, "break framing");
		rc(ADDR_DATA, 32'hff, 32'h0, "break data");
		$display("done errors");
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs();
		t_tx8();
		t_tx9();
		t_brk();
		t_rx();
		t_ovr();
		t_err();
		test_done();
	end
endmodule
